/* File: rtl/bme_core.sv */
// byte move executor with ahb-lite control slave and byte memory port
//
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "bme_params.svh"
module bme_core
  import bme_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic mem_req,
  output logic mem_we,
  output logic [23:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);

  bme_rf_if rf ();

  bme_regfile u_rf (
    .hclk(hclk),
    .hresetn(hresetn),
    .rf(rf)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bme_state_t state_r;
  bme_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [31:0] instr_lo_r;
  logic [31:0] instr_hi_r;
  logic [7:0] flags_r;
  logic [7:0] ld_val_r;
  logic done_r;
  logic illegal_r;
  logic dp_wr_r;
  logic dp_rd_r;
  logic [7:0] dp_addr_r;
  logic rd_ok_r;

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  wire form_ok = instr_lo_r[7:0] <= `BME_FORM_LAST;
  wire bme_form_t form = form_ok ? bme_form_t'(instr_lo_r[3:0]) : BME_F_BAD;
  wire [3:0] dst_f = instr_lo_r[11:8];
  wire [3:0] src_f = instr_lo_r[15:12];
  wire [15:0] d16 = instr_lo_r[31:16];
  wire [23:0] d24 = instr_hi_r[23:0];
  wire [7:0] imm8 = instr_lo_r[23:16];

  function automatic logic [7:0] len_states(input bme_form_t f);
    case (f)
      BME_F_IMM, BME_F_REG: len_states = {`BME_LEN_2, `BME_STATES_2};
      BME_F_LD_IND, BME_F_ST_IND: len_states = {`BME_LEN_2, `BME_STATES_4};
      BME_F_LD_D16, BME_F_ST_D16: len_states = {`BME_LEN_4, `BME_STATES_6};
      BME_F_LD_D24, BME_F_ST_D24: len_states = {`BME_LEN_8, `BME_STATES_10};
      BME_F_LD_PINC: len_states = {`BME_LEN_2, `BME_STATES_6};
      BME_F_LD_ABS8, BME_F_ST_ABS8: len_states = {`BME_LEN_2, `BME_STATES_4};
      BME_F_LD_ABS16, BME_F_ST_ABS16: len_states = {`BME_LEN_4, `BME_STATES_6};
      BME_F_LD_ABS24, BME_F_ST_ABS24: len_states = {`BME_LEN_6, `BME_STATES_8};
      default: len_states = 8'h00;
    endcase
  endfunction

  wire [7:0] ls = len_states(form);
  wire [3:0] ins_len = ls[7:4];
  wire [3:0] ins_states = ls[3:0];

  wire is_store = (form == BME_F_ST_IND) || (form == BME_F_ST_D16)
    || (form == BME_F_ST_D24) || (form == BME_F_ST_ABS8)
    || (form == BME_F_ST_ABS16) || (form == BME_F_ST_ABS24);
  wire is_mem = (form != BME_F_IMM) && (form != BME_F_REG) && (form != BME_F_BAD);
  wire uses_ptr = (form == BME_F_LD_IND) || (form == BME_F_LD_D16)
    || (form == BME_F_LD_D24) || (form == BME_F_LD_PINC)
    || (form == BME_F_ST_IND) || (form == BME_F_ST_D16) || (form == BME_F_ST_D24);

  // ----------------------------------------------------------------
  // operands and effective address
  // ----------------------------------------------------------------
  // pointer is the 32-bit register named by source (loads) or destination (stores)
  wire [2:0] ptr_idx = is_store ? dst_f[2:0] : src_f[2:0];
  // byte register: bit 3 picks low byte, clear picks high byte
  wire [2:0] byte_src_idx = is_store ? src_f[2:0] : src_f[2:0];
  wire [7:0] src_byte = src_f[3] ? rf.rb_data[7:0] : rf.rb_data[15:8];
  wire [31:0] ptr = rf.ra_data;
  wire [31:0] d16_ext = {{16{d16[15]}}, d16};
  wire [31:0] d24_ext = {{8{d24[23]}}, d24};

  wire [31:0] ea =
    ((form == BME_F_LD_D16) || (form == BME_F_ST_D16)) ? ptr + d16_ext :
    ((form == BME_F_LD_D24) || (form == BME_F_ST_D24)) ? ptr + d24_ext :
    ((form == BME_F_LD_ABS8) || (form == BME_F_ST_ABS8)) ? {24'hFFFFFF, imm8} :
    ((form == BME_F_LD_ABS16) || (form == BME_F_ST_ABS16)) ? d16_ext :
    ((form == BME_F_LD_ABS24) || (form == BME_F_ST_ABS24)) ? {8'h00, d24} :
    ptr;

  wire [7:0] move_val = (form == BME_F_IMM) ? imm8 :
    (form == BME_F_REG || is_store) ? src_byte : ld_val_r;

  // ----------------------------------------------------------------
  // ahb-lite decode
  // ----------------------------------------------------------------
  wire idle = state_r == BME_S_IDLE;
  wire ap_valid = hsel && htrans[1] && hready;
  wire dp_gpr = dp_addr_r[7:5] == 3'b001;
  wire wr_ctrl = dp_wr_r && idle && (dp_addr_r == `BME_OFF_CTRL);
  wire wr_ilo = dp_wr_r && idle && (dp_addr_r == `BME_OFF_INSTR_LO);
  wire wr_ihi = dp_wr_r && idle && (dp_addr_r == `BME_OFF_INSTR_HI);
  wire wr_flags = dp_wr_r && idle && (dp_addr_r == `BME_OFF_FLAGS);
  wire wr_gpr = dp_wr_r && idle && dp_gpr;
  wire start = wr_ctrl && hwdata[`BME_CTRL_START];
  wire start_ok = start && (form != BME_F_BAD);

  // port a serves bus reads while idle, the pointer otherwise
  assign rf.ra_idx = !idle ? ptr_idx : (dp_rd_r && dp_gpr) ? dp_addr_r[4:2] : haddr[4:2];
  assign rf.rb_idx = byte_src_idx;

  assign hreadyout = !(dp_rd_r && dp_gpr && !rd_ok_r);
  assign hresp = 1'b0;

  wire [31:0] status_word = {12'h000, ins_states, 4'h0, ins_len, 5'h00,
    illegal_r, done_r, !idle};

  assign hrdata = !dp_rd_r ? 32'h0000_0000 :
    dp_gpr ? rf.ra_data :
    (dp_addr_r == `BME_OFF_STATUS) ? status_word :
    (dp_addr_r == `BME_OFF_INSTR_LO) ? instr_lo_r :
    (dp_addr_r == `BME_OFF_INSTR_HI) ? instr_hi_r :
    (dp_addr_r == `BME_OFF_FLAGS) ? {24'h000000, flags_r} :
    32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r <= 1'b0;
      dp_rd_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else if (hreadyout) begin
      dp_wr_r <= ap_valid && hwrite;
      dp_rd_r <= ap_valid && !hwrite;
      dp_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ok_r <= 1'b0;
    end else begin
      rd_ok_r <= idle;
    end
  end

  // ----------------------------------------------------------------
  // software-visible registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr_lo_r <= `BME_RST_INSTR;
      instr_hi_r <= `BME_RST_INSTR;
    end else begin
      if (wr_ilo) begin
        instr_lo_r <= hwdata;
      end
      if (wr_ihi) begin
        instr_hi_r <= hwdata;
      end
    end
  end

  wire wb_now = state_r == BME_S_WB;
  wire [7:0] flags_upd = {flags_r[7:4], move_val[7], move_val == 8'h00, 1'b0,
    flags_r[`BME_FL_C]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= `BME_RST_FLAGS;
    end else if (wb_now) begin
      flags_r <= flags_upd;
    end else if (wr_flags) begin
      flags_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_r <= 1'b0;
      illegal_r <= 1'b0;
    end else begin
      if (wb_now) begin
        done_r <= 1'b1;
      end else if (start) begin
        done_r <= 1'b0;
      end
      if (start) begin
        illegal_r <= form == BME_F_BAD;
      end
    end
  end

  // ----------------------------------------------------------------
  // execution sequencer: exec for states-2, memory until ack (one cycle without access), writeback
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BME_S_IDLE: begin
        if (start_ok) begin
          state_nxt = (ins_states == `BME_STATES_2) ? BME_S_MEM : BME_S_EXEC;
        end
      end
      BME_S_EXEC: begin
        if (cnt_r == 4'h1) begin
          state_nxt = BME_S_MEM;
        end
      end
      BME_S_MEM: begin
        if (!is_mem || mem_ack) begin
          state_nxt = BME_S_WB;
        end
      end
      BME_S_WB: state_nxt = BME_S_IDLE;
      default: state_nxt = BME_S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= BME_S_IDLE;
      cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      if (start_ok && idle) begin
        cnt_r <= ins_states - `BME_STATES_2;
      end else if (state_r == BME_S_EXEC) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // memory port
  // ----------------------------------------------------------------
  wire mem_phase = (state_r == BME_S_MEM) && is_mem;
  assign mem_req = mem_phase;
  assign mem_we = mem_phase && is_store;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_addr <= 24'h000000;
      mem_wdata <= 8'h00;
    end else if (state_nxt == BME_S_MEM) begin
      mem_addr <= uses_ptr ? ea[23:0] : ea[23:0];
      mem_wdata <= src_byte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ld_val_r <= 8'h00;
    end else if (mem_phase && mem_ack && !is_store) begin
      ld_val_r <= mem_rdata;
    end
  end

  // ----------------------------------------------------------------
  // register writeback
  // ----------------------------------------------------------------
  wire is_load = !is_store && (form != BME_F_BAD);
  wire [3:0] lane_be = dst_f[3] ? 4'b0001 : 4'b0010;

  assign rf.wb_en = (wb_now && is_load) || (wr_gpr && !wb_now);
  assign rf.wb_idx = wb_now ? dst_f[2:0] : dp_addr_r[4:2];
  assign rf.wb_be = wb_now ? lane_be : 4'b1111;
  assign rf.wb_data = wb_now ? {4{move_val}} : hwdata;
  // pointer bump lands under the byte write when both name one register
  assign rf.ww_en = wb_now && (form == BME_F_LD_PINC);
  assign rf.ww_idx = src_f[2:0];
  assign rf.ww_data = ptr + 32'h0000_0001;

endmodule

/* File: rtl/bme_params.svh */
// constants for the byte move execution block
`ifndef BME_PARAMS_SVH
`define BME_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, haddr[7:0])
// ----------------------------------------------------------------
`define BME_OFF_CTRL 8'h00
`define BME_OFF_STATUS 8'h04
`define BME_OFF_INSTR_LO 8'h08
`define BME_OFF_INSTR_HI 8'h0C
`define BME_OFF_FLAGS 8'h10
`define BME_OFF_GPR_BASE 8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BME_CTRL_START 0
`define BME_ST_BUSY 0
`define BME_ST_DONE 1
`define BME_ST_ILLEGAL 2
`define BME_ST_LEN_LSB 8
`define BME_ST_STATES_LSB 16
`define BME_FL_I 7
`define BME_FL_H 5
`define BME_FL_N 3
`define BME_FL_Z 2
`define BME_FL_V 1
`define BME_FL_C 0
`define BME_FORM_LAST 8'h0E

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BME_RST_FLAGS 8'h80
`define BME_RST_INSTR 32'h0000_0000

// ----------------------------------------------------------------
// instruction length in bytes and execution states per form
// ----------------------------------------------------------------
`define BME_LEN_2 4'h2
`define BME_LEN_4 4'h4
`define BME_LEN_6 4'h6
`define BME_LEN_8 4'h8
`define BME_STATES_2 4'h2
`define BME_STATES_4 4'h4
`define BME_STATES_6 4'h6
`define BME_STATES_8 4'h8
`define BME_STATES_10 4'hA

`endif

/* File: rtl/bme_pkg.sv */
// types for the byte move execution block
package bme_pkg;

  // ----------------------------------------------------------------
  // instruction forms (low nibble of instruction byte 0)
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BME_F_IMM = 4'h0,
    BME_F_REG = 4'h1,
    BME_F_LD_IND = 4'h2,
    BME_F_LD_D16 = 4'h3,
    BME_F_LD_D24 = 4'h4,
    BME_F_LD_PINC = 4'h5,
    BME_F_LD_ABS8 = 4'h6,
    BME_F_LD_ABS16 = 4'h7,
    BME_F_LD_ABS24 = 4'h8,
    BME_F_ST_IND = 4'h9,
    BME_F_ST_D16 = 4'hA,
    BME_F_ST_D24 = 4'hB,
    BME_F_ST_ABS8 = 4'hC,
    BME_F_ST_ABS16 = 4'hD,
    BME_F_ST_ABS24 = 4'hE,
    BME_F_BAD = 4'hF
  } bme_form_t;

  // ----------------------------------------------------------------
  // execution sequencer, gray coded along idle-exec-mem-wb
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BME_S_IDLE = 2'b00,
    BME_S_EXEC = 2'b01,
    BME_S_MEM = 2'b11,
    BME_S_WB = 2'b10
  } bme_state_t;

endpackage

/* File: rtl/bme_rf_if.sv */
// carrier between the executor and its general register file
`timescale 1ns/1ps
interface bme_rf_if;
  logic [2:0] ra_idx;
  logic [31:0] ra_data;
  logic [2:0] rb_idx;
  logic [31:0] rb_data;
  logic wb_en;
  logic [2:0] wb_idx;
  logic [3:0] wb_be;
  logic [31:0] wb_data;
  logic ww_en;
  logic [2:0] ww_idx;
  logic [31:0] ww_data;

  modport core (
    output ra_idx, rb_idx, wb_en, wb_idx, wb_be, wb_data, ww_en, ww_idx, ww_data,
    input ra_data, rb_data
  );
  modport rf (
    input ra_idx, rb_idx, wb_en, wb_idx, wb_be, wb_data, ww_en, ww_idx, ww_data,
    output ra_data, rb_data
  );
endinterface

/* File: rtl/bme_regfile.sv */
// eight 32-bit general registers, two registered read ports, two write ports
`timescale 1ns/1ps
module bme_regfile
  import bme_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  bme_rf_if.rf rf
);

  logic [31:0] gpr_r [8];

  // ----------------------------------------------------------------
  // storage: full word write first, byte lanes laid over it
  // ----------------------------------------------------------------
  genvar gi;
  genvar gl;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_ent
      for (gl = 0; gl < 4; gl++) begin : g_lane
        wire ww_hit = rf.ww_en && (rf.ww_idx == 3'(gi));
        wire wb_hit = rf.wb_en && (rf.wb_idx == 3'(gi)) && rf.wb_be[gl];
        always_ff @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            gpr_r[gi][gl*8 +: 8] <= 8'h00;
          end else if (wb_hit) begin
            gpr_r[gi][gl*8 +: 8] <= rf.wb_data[gl*8 +: 8];
          end else if (ww_hit) begin
            gpr_r[gi][gl*8 +: 8] <= rf.ww_data[gl*8 +: 8];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // registered reads
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rf.ra_data <= 32'h0000_0000;
      rf.rb_data <= 32'h0000_0000;
    end else begin
      rf.ra_data <= gpr_r[rf.ra_idx];
      rf.rb_data <= gpr_r[rf.rb_idx];
    end
  end

endmodule

/* File: sim/bme_checker.sv */
// concurrent checks on the byte move executor ports
`timescale 1ns/1ps
module bme_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_ack
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // read data phase tracker
  // ----------------------------------------------------------------
  logic rd_ph_r;
  logic rd_ph_nxt;
  assign rd_ph_nxt = hready ? (hsel && htrans[1] && !hwrite) : rd_ph_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph_r <= 1'b0;
    end else begin
      rd_ph_r <= rd_ph_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_hresp_okay: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  a_write_nowait: assert property (
    hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_stall_read: assert property (!hreadyout |-> rd_ph_r)
    else $error("stall outside read data phase");
  a_ready_recover: assert property (!hreadyout |-> ##[1:64] hreadyout)
    else $error("read stall too long");
  a_rdata_idle: assert property (!rd_ph_r |-> hrdata == 32'h0)
    else $error("read data outside read phase");
  a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_we))
    else $error("memory request dropped before ack");
  a_addr_stable: assert property (mem_req && !mem_ack |=> $stable(mem_addr))
    else $error("memory address moved while pending");
  a_wdata_stable: assert property (
    mem_req && mem_we && !mem_ack |=> $stable(mem_wdata))
    else $error("store byte moved while pending");
  a_req_single: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("second memory access in one move");

  c_store: cover property (mem_req && mem_we && mem_ack);
  c_load: cover property (mem_req && !mem_we && mem_ack);
  c_stall: cover property (!hreadyout);
endmodule

bind bme_core bme_checker chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .mem_req(mem_req),
  .mem_we(mem_we),
  .mem_addr(mem_addr),
  .mem_wdata(mem_wdata),
  .mem_ack(mem_ack)
);

/* File: sim/byte_move_execution_test.sv */
// self-checking bench for the byte move executor
`timescale 1ns/1ps
`define check(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %h, expected %h", $time, (g), (e)); end end
module byte_move_execution_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic mem_req;
  logic mem_we;
  logic [23:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata = 8'h0;
  logic mem_ack = 1'b0;
  logic [7:0] rd_byte = 8'h0;
  logic [23:0] last_addr = 24'h0;
  logic last_we = 1'b0;
  logic [7:0] last_wd = 8'h0;
  int mismatches = 0;
  int tests_run = 0;
  // {length, states} per form code
  logic [7:0] form_cost [0:14] = '{8'h22, 8'h22, 8'h24, 8'h46, 8'h8A, 8'h26, 8'h24,
    8'h46, 8'h68, 8'h24, 8'h46, 8'h8A, 8'h24, 8'h46, 8'h68};

  assign hready = hreadyout;

  bme_core DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack)
  );

  initial begin
    forever #25 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // memory side: ack one cycle late, data line scrambled when idle
  // ----------------------------------------------------------------
  always @(posedge hclk) begin
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= (mem_req && !mem_ack) ? rd_byte : ~rd_byte;
    if (mem_req && mem_ack) begin
      last_addr <= mem_addr;
      last_we <= mem_we;
      last_wd <= mem_wdata;
    end
  end

  // ----------------------------------------------------------------
  // bus and helper tasks
  // ----------------------------------------------------------------
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] rdat);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rdat = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask

  task automatic run(input logic [31:0] lo, input logic [31:0] hi, output logic [31:0] st);
    int n;
    wr(32'h08, lo);
    wr(32'h0C, hi);
    wr(32'h00, 32'h1);
    n = 0;
    rd(32'h04, st);
    while (st[0] !== 1'b0 && n < 40) begin
      rd(32'h04, st);
      n++;
    end
    if (st[0] !== 1'b0) begin
      mismatches++;
      $display("Error at %0t: executor still busy after poll limit", $time);
    end
  endtask

  task automatic expect_mem(input logic [23:0] a, input logic we, input logic [7:0] fl);
    logic [31:0] v;
    `check(last_addr, a)
    `check(last_we, we)
    rd(32'h10, v);
    `check(v[7:0], fl)
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    logic [31:0] v;
    rd(32'h10, v);
    `check(v[7:0], 8'h80)
    rd(32'h34, v);
    `check(v, 32'h0)
    rd(32'h40, v);
    `check(v, 32'h0)
    rd(32'h04, v);
    `check(v, 32'h0002_0200)
  endtask

  task automatic t_load_d16;
    logic [31:0] v;
    wr(32'h24, 32'h0000_1000);
    wr(32'h28, 32'h1234_5678);
    wr(32'h10, 32'h0000_00A3);
    rd_byte <= 8'h80;
    run({16'hFFFE, 4'h1, 4'hA, 8'h03}, 32'h0, v);
    `check(v[11:8], 4'h4)
    `check(v[19:16], 4'h6)
    expect_mem(24'h000FFE, 1'b0, 8'hA9);
    rd(32'h28, v);
    `check(v, 32'h1234_5680)
  endtask

  task automatic t_load_d24;
    logic [31:0] v;
    rd_byte <= 8'h00;
    run({16'h0000, 4'h1, 4'h2, 8'h04}, 32'h0000_0010, v);
    `check(v[11:8], 4'h8)
    expect_mem(24'h001010, 1'b0, 8'hA5);
    rd(32'h28, v);
    `check(v, 32'h1234_0080)
  endtask

  task automatic t_stores;
    logic [31:0] v;
    run({16'h0004, 4'hA, 4'h1, 8'h0A}, 32'h0, v);
    `check(v[11:8], 4'h4)
    `check(v[19:16], 4'h6)
    expect_mem(24'h001004, 1'b1, 8'hA9);
    `check(last_wd, 8'h80)
    run({16'h0000, 4'h2, 4'h1, 8'h0B}, 32'h00FF_FFFF, v);
    `check(v[11:8], 4'h8)
    expect_mem(24'h000FFF, 1'b1, 8'hA5);
    `check(last_wd, 8'h00)
  endtask

  task automatic t_post_inc;
    logic [31:0] v;
    rd_byte <= 8'h7F;
    run({16'h0000, 4'h1, 4'hB, 8'h05}, 32'h0, v);
    `check(v[11:8], 4'h2)
    `check(v[19:16], 4'h6)
    expect_mem(24'h001000, 1'b0, 8'hA1);
    rd(32'h24, v);
    `check(v, 32'h0000_1001)
    rd(32'h2C, v);
    `check(v, 32'h0000_007F)
  endtask

  // register read stalls while busy; flag write while busy is dropped
  task automatic t_busy_read;
    logic [31:0] v;
    rd_byte <= 8'h5A;
    wr(32'h08, {16'h0000, 4'h1, 4'h2, 8'h02});
    wr(32'h00, 32'h1);
    wr(32'h10, 32'h0);
    rd(32'h28, v);
    `check(v, 32'h1234_5A80)
    expect_mem(24'h001001, 1'b0, 8'hA1);
  endtask

  task automatic t_forms;
    logic [31:0] v;
    for (int f = 0; f < 15; f++) begin
      run({16'h0002, 4'h1, 4'h9, 4'h0, f[3:0]}, 32'h0, v);
      `check(v[11:8], form_cost[f][7:4])
      `check(v[19:16], form_cost[f][3:0])
      `check(v[2:1], 2'b01)
    end
    run({24'h0, 8'h0F}, 32'h0, v);
    `check(v[2:1], 2'b10)
  endtask

  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    mismatches++;
    give_verdict;
  end

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_values;
    t_load_d16;
    t_load_d24;
    t_stores;
    t_post_inc;
    t_busy_read;
    t_forms;
    give_verdict;
  end
endmodule
